// ### logic/codec_map.vh
// Register map, field layout and timing constants of the disk byte codec.
`ifndef CODEC_MAP_VH
`define CODEC_MAP_VH

`define AXI_ADDR_W 5
`define OFS_STATUS 5'h00
`define OFS_COMMAND 5'h04
`define OFS_DATA 5'h08
`define OFS_CONFIG 5'h0c
`define WORD_MASK 5'h1c

`define IDX_STATUS 3'h0
`define IDX_COMMAND 3'h1
`define IDX_DATA 3'h2
`define IDX_CONFIG 3'h3
`define IDX_NONE 3'h4

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define ST_BUSY 0
`define ST_REQUEST 1
`define ST_LOST 2
`define ST_MFM 3
`define ST_SIDE 4

`define CMD_READ 0
`define CMD_WRITE 1
`define CMD_SIDE 2
`define CMD_ABORT 3

`define CFG_GAP 7:0
`define CFG_SECTORS 15:8
`define CFG_LENGTH 26:16
`define CFG_RESET 32'h0080_0110

`define GAP_FILL 8'h4e
`define ADDR_MARK 8'ha1
`define DATA_RESET 8'h00

`define CLK_PERIOD_NS 8
`define FM_CELL_NS 4000
`define MFM_CELL_NS 2000
`define PULSE_NS 200
`define FM_CELL_CYC (`FM_CELL_NS / `CLK_PERIOD_NS)
`define MFM_CELL_CYC (`MFM_CELL_NS / `CLK_PERIOD_NS)
`define PULSE_CYC ((`PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### logic/pin_sync.v
// Three-stage pin synchroniser that accepts a level once two stages agree.
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 1
) (
  input wire clock,
  input wire reset_n,
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] level
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg s1, s2, s3, held;
      always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          s1 <= 1'h0;
          s2 <= 1'h0;
          s3 <= 1'h0;
          held <= 1'h0;
        end else begin
          s1 <= pin_in[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            held <= s3;
          end
        end
      end
      assign level[i] = held;
    end
  endgenerate
endmodule // pin_sync

// ### logic/cell_encoder.v
// Bit-cell encoder that turns bytes into FM or MFM write pulses.
`timescale 1ns/1ps
`include "codec_map.vh"
module cell_encoder (
  input wire clock,
  input wire reset_n,
  input wire mfm,
  input wire byte_valid,
  input wire [7:0] byte_in,
  output reg byte_taken,
  output reg busy,
  output reg write_pulse
);
  localparam integer FM_LAST_I = `FM_CELL_CYC - 1;
  localparam integer MFM_LAST_I = `MFM_CELL_CYC - 1;
  localparam integer FM_MID_I = `FM_CELL_CYC / 2;
  localparam integer MFM_MID_I = `MFM_CELL_CYC / 2;
  localparam integer PULSE_LAST_I = `PULSE_CYC - 1;
  // Counts are cut to the counter widths on purpose.
  localparam [8:0] FM_LAST = FM_LAST_I[8:0];
  localparam [8:0] MFM_LAST = MFM_LAST_I[8:0];
  localparam [8:0] FM_MID = FM_MID_I[8:0];
  localparam [8:0] MFM_MID = MFM_MID_I[8:0];
  localparam [4:0] PULSE_LAST = PULSE_LAST_I[4:0];
  reg [7:0] shift;
  reg [2:0] bits_left;
  reg [8:0] cnt;
  reg prev_bit;
  reg [4:0] pulse_cnt;
  // R9 R12 cell length
  wire [8:0] cell_last = mfm ? MFM_LAST : FM_LAST;
  wire [8:0] cell_mid = mfm ? MFM_MID : FM_MID;
  // R7 R11 clock at boundary
  wire clock_mark = mfm ? (!prev_bit && !shift[7]) : 1'h1;
  // R8 R10 data at centre
  wire fire = busy && ((cnt == 9'h000 && clock_mark) ||
              (cnt == cell_mid && shift[7]));
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      byte_taken <= 1'h0;
      busy <= 1'h0;
      write_pulse <= 1'h0;
      shift <= 8'h00;
      bits_left <= 3'h0;
      cnt <= 9'h000;
      prev_bit <= 1'h1;
      pulse_cnt <= 5'h00;
    end else begin
      byte_taken <= 1'h0;
      if (!busy) begin
        if (byte_valid) begin
          shift <= byte_in;
          bits_left <= 3'h7;
          cnt <= 9'h000;
          busy <= 1'h1;
          byte_taken <= 1'h1;
        end
      // R7 eight cells per byte
      end else if (cnt == cell_last) begin
        cnt <= 9'h000;
        prev_bit <= shift[7];
        if (bits_left == 3'h0) begin
          if (byte_valid) begin
            shift <= byte_in;
            bits_left <= 3'h7;
            byte_taken <= 1'h1;
          end else begin
            busy <= 1'h0;
          end
        end else begin
          shift <= {shift[6:0], 1'h0};
          bits_left <= bits_left - 3'h1;
        end
      end else begin
        cnt <= cnt + 9'h001;
      end
      if (fire) begin
        write_pulse <= 1'h1;
        pulse_cnt <= PULSE_LAST;
      end else if (pulse_cnt != 5'h00) begin
        pulse_cnt <= pulse_cnt - 5'h01;
      end else begin
        write_pulse <= 1'h0;
      end
    end
  end
endmodule // cell_encoder

// ### logic/fm_mfm_codec.v
// Floppy byte codec: AXI4-Lite registers, byte request, FM/MFM streams.
// Summary of operation
// R1: One byte request per byte moved.
// R2: Read: assembled byte sets status request bit.
// R3: Host data read clears bit and line.
// R4: Request rises again for each next byte.
// R5: Write: host data write clears both requests.
// R6: Host serves each request within byte time.
// R7: FM: eight cells, clock at each start.
// R8: FM: centre pulse for one, none zero.
// R9: FM cells spaced four microseconds.
// R10: MFM: centre pulse for a one bit.
// R11: MFM clock only between two zeros.
// R12: MFM cell lasts two microseconds.
// R13: Sectors found by address marks only.
// R14: Gap and sector lengths are configurable.
// R15: Open density pin means FM only.
// R16: Side select output set by command.
// R17: Status bit one mirrors byte request.
// R18: Status bit two flags a missed request.
// R19: Density pin high FM, low MFM.
// R20: Density picks encoding, handshake unchanged.
`timescale 1ns/1ps
`include "codec_map.vh"
module fm_mfm_codec (
  input wire clock,
  input wire reset_n,
  input wire awvalid,
  output reg awready,
  input wire [`AXI_ADDR_W-1:0] awaddr,
  input wire wvalid,
  output reg wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  input wire arvalid,
  output reg arready,
  input wire [`AXI_ADDR_W-1:0] araddr,
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  input wire density_select_n,
  input wire read_clock,
  input wire read_data,
  output reg byte_request,
  output reg write_gate,
  output wire write_pulse,
  output reg side_select
);
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_HUNT = 7'h02;
  localparam [6:0] S_RDATA = 7'h04;
  localparam [6:0] S_WGAP = 7'h08;
  localparam [6:0] S_WMARK = 7'h10;
  localparam [6:0] S_WDATA = 7'h20;
  localparam [6:0] S_WDRAIN = 7'h40;

  // Word decode shared by the read and write channels.
  function [2:0] reg_index;
    input [`AXI_ADDR_W-1:0] addr;
    begin
      case (addr & `WORD_MASK)
        `OFS_STATUS: reg_index = `IDX_STATUS;
        `OFS_COMMAND: reg_index = `IDX_COMMAND;
        `OFS_DATA: reg_index = `IDX_DATA;
        `OFS_CONFIG: reg_index = `IDX_CONFIG;
        default: reg_index = `IDX_NONE;
      endcase
    end
  endfunction

  reg aw_got, w_got;
  reg [`AXI_ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [6:0] state;
  reg [7:0] data_reg;
  reg [7:0] shift;
  reg [2:0] bit_cnt;
  reg [10:0] byte_cnt;
  reg [7:0] sector_cnt;
  reg lost;
  reg mfm_mode;
  reg clk_prev;
  reg [31:0] config_reg;
  reg [6:0] next_state;
  reg next_set_req;
  reg next_set_lost;
  reg [7:0] enc_byte;
  reg enc_valid;
  wire [2:0] pins;
  wire enc_taken;
  wire enc_busy;

  wire wr_fire = aw_got && w_got && !bvalid;
  wire [2:0] wr_idx = reg_index(aw_addr);
  wire rd_fire = arvalid && arready;
  wire [2:0] rd_idx = reg_index(araddr);
  wire dens_n = pins[2];
  wire clk_s = pins[1];
  wire bit_s = pins[0];
  wire bit_tick = clk_s && !clk_prev;
  wire [7:0] rx_byte = {shift[6:0], bit_s};
  wire [7:0] gap_len = config_reg[`CFG_GAP];
  wire [7:0] sectors = config_reg[`CFG_SECTORS];
  wire [10:0] sec_len = config_reg[`CFG_LENGTH];
  wire last_byte = byte_cnt == sec_len - 11'h001;
  wire last_sector = sector_cnt == sectors - 8'h01;
  wire busy = state != S_IDLE;
  wire cmd_wr = wr_fire && wr_idx == `IDX_COMMAND && w_strb[0];
  wire start_rd = cmd_wr && !busy && w_data[`CMD_READ];
  wire start_wr = cmd_wr && !busy && !w_data[`CMD_READ] &&
                  w_data[`CMD_WRITE];
  wire abort = cmd_wr && w_data[`CMD_ABORT];
  // R3 host read clears
  wire host_rd = rd_fire && rd_idx == `IDX_DATA;
  // R5 host write clears
  wire host_wr = wr_fire && wr_idx == `IDX_DATA && w_strb[0];
  wire [31:0] status_word = {27'h000_0000, side_select, mfm_mode, lost,
                             byte_request, busy};

  // Pins come from the drive and the board, outside the clock domain.
  pin_sync #(
    .WIDTH(3)
  ) u_pins (
    .clock(clock),
    .reset_n(reset_n),
    .pin_in({density_select_n, read_clock, read_data}),
    .level(pins)
  );

  cell_encoder u_enc (
    .clock(clock),
    .reset_n(reset_n),
    .mfm(mfm_mode),
    .byte_valid(enc_valid),
    .byte_in(enc_byte),
    .byte_taken(enc_taken),
    .busy(enc_busy),
    .write_pulse(write_pulse)
  );

  // One write at a time; address and data may come in either order.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      awready <= 1'h1;
      wready <= 1'h1;
      aw_got <= 1'h0;
      w_got <= 1'h0;
      aw_addr <= 5'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'h0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got <= 1'h1;
        aw_addr <= awaddr;
        awready <= 1'h0;
      end
      if (wvalid && wready) begin
        w_got <= 1'h1;
        w_data <= wdata;
        w_strb <= wstrb;
        wready <= 1'h0;
      end
      if (wr_fire) begin
        aw_got <= 1'h0;
        w_got <= 1'h0;
        bvalid <= 1'h1;
        bresp <= (wr_idx == `IDX_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (bvalid && bready) begin
        bvalid <= 1'h0;
        awready <= 1'h1;
        wready <= 1'h1;
      end
    end
  end

  // Read answers one cycle after the address is taken.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      arready <= 1'h1;
      rvalid <= 1'h0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else begin
      if (rd_fire) begin
        arready <= 1'h0;
        rvalid <= 1'h1;
        rresp <= `RESP_OKAY;
        case (rd_idx)
          // R17 status mirrors request
          `IDX_STATUS: rdata <= status_word;
          `IDX_DATA: rdata <= {24'h00_0000, data_reg};
          `IDX_CONFIG: rdata <= config_reg;
          `IDX_COMMAND: rdata <= 32'h0000_0000;
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'h0;
        arready <= 1'h1;
      end
    end
  end

  // Sequencer: next state and the request and loss events.
  always @* begin
    next_state = state;
    next_set_req = 1'h0;
    next_set_lost = 1'h0;
    enc_byte = `GAP_FILL;
    enc_valid = 1'h0;
    case (state)
      S_IDLE: begin
        if (start_rd) begin
          next_state = S_HUNT;
        end else if (start_wr) begin
          next_state = S_WGAP;
          next_set_req = 1'h1;
        end
      end
      // R13 hunt for mark
      S_HUNT: begin
        if (bit_tick && rx_byte == `ADDR_MARK) begin
          next_state = S_RDATA;
        end
      end
      S_RDATA: begin
        if (bit_tick && bit_cnt == 3'h7) begin
          // R1 R2 byte assembled
          next_set_req = 1'h1;
          // R18 missed request
          next_set_lost = byte_request;
          if (last_byte) begin
            next_state = last_sector ? S_IDLE : S_HUNT;
          end
        end
      end
      // R14 gap length
      S_WGAP: begin
        enc_valid = 1'h1;
        if (enc_taken && byte_cnt + 11'h001 >= {3'h0, gap_len}) begin
          next_state = S_WMARK;
        end
      end
      S_WMARK: begin
        enc_valid = 1'h1;
        enc_byte = `ADDR_MARK;
        if (enc_taken) begin
          next_state = S_WDATA;
        end
      end
      S_WDATA: begin
        enc_valid = 1'h1;
        enc_byte = data_reg;
        if (enc_taken) begin
          // R18 register not refilled
          next_set_lost = byte_request;
          // R4 request next byte
          next_set_req = !(last_byte && last_sector);
          if (last_byte) begin
            next_state = last_sector ? S_WDRAIN : S_WGAP;
          end
        end
      end
      S_WDRAIN: begin
        if (!enc_busy) begin
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
    if (abort) begin
      next_state = S_IDLE;
      next_set_req = 1'h0;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= S_IDLE;
      data_reg <= `DATA_RESET;
      shift <= 8'h00;
      bit_cnt <= 3'h0;
      byte_cnt <= 11'h000;
      sector_cnt <= 8'h00;
      byte_request <= 1'h0;
      lost <= 1'h0;
      mfm_mode <= 1'h0;
      clk_prev <= 1'h0;
      write_gate <= 1'h0;
      side_select <= 1'h0;
      config_reg <= `CFG_RESET;
    end else begin
      state <= next_state;
      clk_prev <= clk_s;
      if (bit_tick) begin
        shift <= rx_byte;
      end
      // R16 side from command
      if (cmd_wr) begin
        side_select <= w_data[`CMD_SIDE];
      end
      // R14 configurable format
      if (wr_fire && wr_idx == `IDX_CONFIG && !busy) begin
        if (w_strb[0]) config_reg[7:0] <= w_data[7:0];
        if (w_strb[1]) config_reg[15:8] <= w_data[15:8];
        if (w_strb[2]) config_reg[23:16] <= w_data[23:16];
        if (w_strb[3]) config_reg[31:24] <= {5'h00, w_data[26:24]};
      end
      if (start_rd || start_wr) begin
        // R19 R20 R15 density latched
        mfm_mode <= !dens_n;
        byte_cnt <= 11'h000;
        sector_cnt <= 8'h00;
        bit_cnt <= 3'h0;
      end
      if (state == S_HUNT && next_state == S_RDATA) begin
        bit_cnt <= 3'h0;
        byte_cnt <= 11'h000;
      end
      if (state == S_RDATA && bit_tick) begin
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          data_reg <= rx_byte;
          byte_cnt <= byte_cnt + 11'h001;
          if (last_byte) begin
            sector_cnt <= sector_cnt + 8'h01;
          end
        end
      end else if (host_wr) begin
        data_reg <= w_data[7:0];
      end
      if (enc_taken && state != S_WMARK) begin
        byte_cnt <= byte_cnt + 11'h001;
      end
      if (enc_taken && state == S_WMARK) begin
        byte_cnt <= 11'h000;
      end
      if (enc_taken && state == S_WDATA && last_byte) begin
        byte_cnt <= 11'h000;
        sector_cnt <= sector_cnt + 8'h01;
      end
      if (start_wr) begin
        write_gate <= 1'h1;
      end else if (next_state == S_IDLE && (abort || !enc_busy)) begin
        write_gate <= 1'h0;
      end
      // R3 R5 R17 set wins clear
      if (next_set_req) begin
        byte_request <= 1'h1;
      end else if (host_rd || host_wr || abort) begin
        byte_request <= 1'h0;
      end
      // R6 R18 lost cleared on start
      if (next_set_lost) begin
        lost <= 1'h1;
      end else if (start_rd || start_wr) begin
        lost <= 1'h0;
      end
    end
  end
endmodule // fm_mfm_codec

// ### testbench/codec_monitor.sv
// Concurrent checks on the codec's register bus and drive-side pins.
`timescale 1ns/1ps
`include "codec_map.vh"
module codec_monitor (
  input wire clock,
  input wire reset_n,
  input wire awvalid,
  input wire awready,
  input wire [`AXI_ADDR_W-1:0] awaddr,
  input wire wvalid,
  input wire wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire bvalid,
  input wire [1:0] bresp,
  input wire arvalid,
  input wire arready,
  input wire [`AXI_ADDR_W-1:0] araddr,
  input wire rvalid,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire density_select_n,
  input wire byte_request,
  input wire write_gate,
  input wire write_pulse,
  input wire side_select
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  reg prev_pulse;
  reg have;
  reg [9:0] since;
  wire rise = write_pulse && !prev_pulse;
  // The first pulse of a gate has no valid predecessor, so it only arms.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prev_pulse <= 1'h0;
      have <= 1'h0;
      since <= 10'h000;
    end else begin
      prev_pulse <= write_pulse;
      have <= write_gate && (have || rise);
      if (rise) since <= 10'h001;
      else if (since != 10'h3ff) since <= since + 10'h001;
    end
  end
  sequence wr_hs;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_hs;
    arvalid && arready;
  endsequence
  property side_p;
    wr_hs ##0 (awaddr == `OFS_COMMAND && wstrb[0])
      |-> ##2 side_select == $past(wdata[`CMD_SIDE], 2);
  endproperty
  resp_after_a: assert property (
    wr_hs |=> (!awready && !wready) ##1 bvalid)
    else $error("write response timing wrong");
  read_clear_a: assert property (
    rd_hs ##0 (araddr == `OFS_DATA) |=> !byte_request)
    else $error("data read left byte request set");
  write_clear_a: assert property (
    wr_hs ##0 (awaddr == `OFS_DATA && wstrb[0]) |-> ##[1:2] !byte_request)
    else $error("data write left byte request set");
  gate_request_a: assert property ($rose(write_gate) |-> byte_request)
    else $error("write start without byte request");
  pulse_width_a: assert property (
    $rose(write_pulse)
      |-> write_pulse[*8] ##17 write_pulse ##1 !write_pulse)
    else $error("write pulse width wrong");
  pulse_gap_a: assert property (
    rise && have |-> since == 250 || since == 500
      || (!density_select_n && since == 375))
    else $error("write pulse spacing off grid");
  side_level_a: assert property (side_p)
    else $error("side select does not follow command");
  write_err_a: assert property (
    wr_hs ##0 (awaddr >= 5'h10) |-> ##2 bvalid && bresp == `RESP_SLVERR)
    else $error("unmapped write not refused");
  read_err_a: assert property (rd_hs ##0 (araddr >= 5'h10)
    |=> rvalid && rresp == `RESP_SLVERR && rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
endmodule // codec_monitor
bind fm_mfm_codec codec_monitor mon_u (.*);

// ### testbench/disk_model.sv
// Drive model: serial read stream source and write pulse recorder.
`timescale 1ns/1ps
module disk_model (
  input wire clock,
  input wire write_pulse,
  output logic read_clock,
  output logic read_data
);
  int cycle = 0;
  int rises[$];
  logic last_pulse = 1'h0;
  initial begin
    read_clock = 1'h0;
    read_data = 1'h0;
  end
  // Sampled off the edge so the pulse register has settled.
  always @(negedge clock) begin
    cycle <= cycle + 1;
    last_pulse <= write_pulse;
    if (write_pulse && !last_pulse) rises.push_back(cycle);
  end
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clock);
      read_data <= b[i];
      repeat (4) @(posedge clock);
      read_clock <= 1'h1;
      repeat (4) @(posedge clock);
      read_clock <= 1'h0;
    end
    @(posedge clock);
    // The line is undriven between frames; show a changed level.
    read_data <= ~read_data;
  endtask
endmodule // disk_model

// ### testbench/tb.sv
// Self-checking bench for the floppy byte codec.
`timescale 1ns/1ps
`include "codec_map.vh"
module tb;
  logic clock = 1'h0;
  logic reset_n = 1'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [4:0] awaddr = 5'h00;
  logic [4:0] araddr = 5'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic density_select_n = 1'h1;
  wire awready, wready, bvalid, arready, rvalid, read_clock, read_data;
  wire byte_request, write_gate, write_pulse, side_select;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int failures = 0;
  int num_checks = 0;
  logic [1:0] resp;
  logic [31:0] val;
  always #4 clock = ~clock;
  fm_mfm_codec dut_u (.*);
  disk_model drive_u (.*);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    if (failures == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Ready is a register, so its negedge value is what the next edge sees.
  task axi_write(input logic [4:0] a, input logic [31:0] d);
    logic ah, wh, ad, wd;
    // One edge passes so the previous call's release is not overwritten.
    @(posedge clock);
    ad = 1'h0;
    wd = 1'h0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ad && wd)) begin
      @(negedge clock);
      ah = awvalid && awready;
      wh = wvalid && wready;
      @(posedge clock);
      if (ah) awvalid <= 1'h0;
      if (wh) wvalid <= 1'h0;
      ad = ad || ah;
      wd = wd || wh;
    end
    do @(negedge clock); while (!bvalid);
    resp = bresp;
    @(posedge clock);
    bready <= 1'h0;
  endtask
  task axi_read(input logic [4:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(negedge clock); while (!arready);
    @(posedge clock);
    arvalid <= 1'h0;
    do @(negedge clock); while (!rvalid);
    val = rdata;
    resp = rresp;
    @(posedge clock);
    rready <= 1'h0;
  endtask
  task pin_is(input logic e, input int cyc);
    @(negedge clock);
    for (int n = 0; n < cyc && byte_request !== e; n++) @(negedge clock);
    chk(byte_request, e);
    @(posedge clock);
  endtask
  task t_regs;
    axi_read(`OFS_CONFIG);
    chk(val, `CFG_RESET);
    axi_write(`OFS_STATUS, 32'h0000_001f);
    chk(resp, `RESP_OKAY);
    axi_read(`OFS_STATUS);
    chk(val, 32'h0000_0000);
    axi_write(5'h10, 32'h0000_0001);
    chk(resp, `RESP_SLVERR);
    axi_read(5'h1c);
    chk(resp, `RESP_SLVERR);
    chk(val, 32'h0000_0000);
  endtask
  task t_side;
    axi_write(`OFS_COMMAND, 32'h0000_0004);
    axi_read(`OFS_STATUS);
    chk(val & 32'h0000_0010, 32'h0000_0010);
    axi_write(`OFS_COMMAND, 32'h0000_0000);
    axi_read(`OFS_STATUS);
    chk(val & 32'h0000_0010, 32'h0000_0000);
  endtask
  task t_read;
    axi_write(`OFS_CONFIG, 32'h0003_0101);
    axi_write(`OFS_COMMAND, 32'h0000_0001);
    drive_u.send_byte(8'h3c);
    pin_is(1'h0, 0);
    drive_u.send_byte(8'ha1);
    drive_u.send_byte(8'h3c);
    pin_is(1'h1, 40);
    axi_read(`OFS_STATUS);
    chk(val & 32'h0000_0007, 32'h0000_0003);
    axi_read(`OFS_DATA);
    chk(val, 32'h0000_003c);
    pin_is(1'h0, 0);
    drive_u.send_byte(8'hc3);
    pin_is(1'h1, 40);
    drive_u.send_byte(8'h5a);
    axi_read(`OFS_STATUS);
    chk(val & 32'h0000_0006, 32'h0000_0006);
    axi_read(`OFS_DATA);
    chk(val, 32'h0000_005a);
  endtask
  task decode(input logic mfm);
    logic [47:0] exp;
    logic [47:0] seen;
    logic [23:0] bits;
    int half;
    int base;
    int s;
    bits = 24'h4e_a1d2;
    half = mfm ? 125 : 250;
    base = drive_u.rises[0];
    for (int pass = 0; pass < 2; pass++) begin
      seen = 48'h0000_0000_0000;
      foreach (drive_u.rises[i]) begin
        s = (drive_u.rises[i] - base) / half;
        if (s < 48)
          seen[s] = (s * half == drive_u.rises[i] - base) ? 1'h1 : 1'hx;
      end
      // A leading MFM data pulse belongs in slot 3; taken as slot 0, a pulse shows in slot 8.
      if (mfm && seen[8] === 1'h1) base -= 375;
    end
    if (mfm) seen[0] = 1'h0;
    for (int k = 0; k < 24; k++) begin
      exp[2*k+1] = bits[23-k];
      exp[2*k] = !mfm || (k > 0 && !bits[24-k] && !bits[23-k]);
    end
    chk(seen[31:0], exp[31:0]);
    chk(seen[47:32], exp[47:32]);
  endtask
  task t_write(input logic mfm);
    axi_write(`OFS_COMMAND, 32'h0000_0008);
    density_select_n <= !mfm;
    repeat (8) @(posedge clock);
    axi_write(`OFS_CONFIG, 32'h0001_0101);
    drive_u.rises.delete();
    axi_write(`OFS_COMMAND, 32'h0000_0002);
    pin_is(1'h1, 0);
    axi_read(`OFS_STATUS);
    chk(val & 32'h0000_0009, {mfm, 3'h1});
    axi_write(`OFS_DATA, 32'h0000_00d2);
    pin_is(1'h0, 0);
    @(negedge clock);
    for (int n = 0; n < 30000 && write_gate; n++) @(negedge clock);
    chk(write_gate, 1'h0);
    @(posedge clock);
    decode(mfm);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'h1;
    repeat (5) @(posedge clock);
    t_regs;
    t_side;
    t_read;
    t_write(1'h0);
    t_write(1'h1);
    print_verdict;
  end
  initial begin
    #400_000;
    failures++;
    print_verdict;
  end
endmodule // tb
